// [logic/amc_pkg.sv]
// Package for the asynchronous memory host controller
package amc_pkg;
  localparam int ADDR_W        = 21;
  localparam int DATA_W        = 16;
  localparam int CLK_PERIOD_PS = 8000;
  // Timing minima in ns (startup in us), standard grade then extended temperature grade
  localparam int T_CYCLE_NS      = 35;
  localparam int T_CYCLE_AUTO_NS = 45;
  localparam int T_AV_END_NS     = 20;
  localparam int T_AV_END_AUTO_NS = 30;
  localparam int T_WPULSE_NS     = 15;
  localparam int T_DSETUP_NS     = 10;
  localparam int T_RECOVERY_NS   = 12;
  localparam int T_HIGH_NS       = 2;
  localparam int T_GACC_NS       = 15;
  localparam int T_GHZ_NS        = 10;
  localparam int T_EHZ_NS        = 15;
  localparam int T_STARTUP_US    = 2000;
  // Least times rounded up to whole clock periods
  function automatic int ns2cyc(input int ns);
    int c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction : ns2cyc
  localparam int STARTUP_CYC = (T_STARTUP_US * 1000 * 1000) / CLK_PERIOD_PS;
  localparam int CNT_W       = 20;

  typedef enum logic [2:0] {
    AMC_ST_BOOT  = 3'b111,
    AMC_ST_IDLE  = 3'b001,
    AMC_ST_RACC  = 3'b011,
    AMC_ST_RFLT  = 3'b010,
    AMC_ST_WPUL  = 3'b101,
    AMC_ST_WREC  = 3'b100,
    AMC_ST_GAP   = 3'b000
  } amc_state_t;

  typedef struct packed {
    logic              write;
    logic [1:0]        byte_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } amc_req_t;

  typedef struct packed {
    logic              chip_sel_n;
    logic              write_n;
    logic              out_drv_n;
    logic              upper_byte_sel_n;
    logic              lower_byte_sel_n;
    logic [ADDR_W-1:0] addr;
  } amc_ctl_t;
endpackage : amc_pkg

// [logic/amc_host.sv]
// Host sequencer driving a clockless asynchronous 16-bit memory
`timescale 1ns/10ps
`default_nettype none
module amc_host
  import amc_pkg::*;
#(
  parameter bit AUTO_GRADE  = 1'b0,
  parameter int STARTUP_CNT = STARTUP_CYC
) (
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire amc_pkg::amc_req_t     req,
  input  wire logic                  req_valid,
  output logic                       req_ready,
  output logic [amc_pkg::DATA_W-1:0] rd_data,
  output logic                       rd_valid,
  output amc_pkg::amc_ctl_t          mem_ctl,
  input  wire logic [amc_pkg::DATA_W-1:0] mem_dq_in,
  output logic [amc_pkg::DATA_W-1:0] mem_dq_out,
  output logic                       mem_dq_oe
);
  import amc_pkg::*;

  localparam int CYC_CYCLE = ns2cyc(AUTO_GRADE ? T_CYCLE_AUTO_NS : T_CYCLE_NS);
  localparam int CYC_AVEND = ns2cyc(AUTO_GRADE ? T_AV_END_AUTO_NS : T_AV_END_NS);
  localparam int CYC_WPUL  = (ns2cyc(T_WPULSE_NS) > CYC_AVEND) ? ns2cyc(T_WPULSE_NS) : CYC_AVEND;
  localparam int CYC_DSU   = ns2cyc(T_DSETUP_NS);
  localparam int CYC_WP    = (CYC_WPUL > CYC_DSU) ? CYC_WPUL : CYC_DSU;
  localparam int CYC_REC   = ns2cyc(T_RECOVERY_NS) > ns2cyc(T_HIGH_NS) ? ns2cyc(T_RECOVERY_NS) : ns2cyc(T_HIGH_NS);
  localparam int CYC_RACC  = ns2cyc(AUTO_GRADE ? T_CYCLE_AUTO_NS : T_CYCLE_NS) + 1;
  localparam int CYC_RFLT  = ns2cyc(T_EHZ_NS) > ns2cyc(T_GHZ_NS) ? ns2cyc(T_EHZ_NS) : ns2cyc(T_GHZ_NS);

  amc_state_t        state_q, state_d;
  logic [CNT_W-1:0]  cnt_q, cnt_d;
  logic [CNT_W-1:0]  span_q, span_d;
  amc_req_t          cur_q, cur_d;
  amc_ctl_t          ctl_q, ctl_d;
  logic              oe_q, oe_d;
  logic [DATA_W-1:0] rdat_q, rdat_d;
  logic              rval_q, rval_d;
  logic [DATA_W-1:0] dq_s1_q, dq_s2_q;
  logic [DATA_W-1:0] dq_s1_d, dq_s2_d;

  // Two-stage synchroniser on the data pins
  always_comb begin
    dq_s1_d = mem_dq_in;
    dq_s2_d = dq_s1_q;
  end

  always_ff @(posedge clk) begin
    dq_s1_q <= dq_s1_d;
    dq_s2_q <= dq_s2_d;
  end

  // Ready only once select spacing elapsed
  assign req_ready  = (state_q == AMC_ST_IDLE) && (span_q >= CNT_W'(CYC_CYCLE));
  assign rd_data    = rdat_q;
  assign rd_valid   = rval_q;
  assign mem_ctl    = ctl_q;
  assign mem_dq_out = cur_q.wdata;
  assign mem_dq_oe  = oe_q;

  // Cycles since last select fall, saturating
  always_comb begin
    span_d = span_q;
    if (state_q == AMC_ST_BOOT) begin
      span_d = CNT_W'(CYC_CYCLE);
    end else if (req_valid && req_ready) begin
      span_d = '0;
    end else if (span_q != {CNT_W{1'b1}}) begin
      span_d = span_q + CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      span_q <= '0;
    end else begin
      span_q <= span_d;
    end
  end

  // Word taken after access and sync delay
  always_comb begin
    rdat_d = rdat_q;
    rval_d = 1'b0;
    if ((state_q == AMC_ST_RACC) && (cnt_q >= CNT_W'(CYC_RACC + 1))) begin
      rdat_d = dq_s2_q;
      rval_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdat_q <= '0;
      rval_q <= 1'b0;
    end else begin
      rdat_q <= rdat_d;
      rval_q <= rval_d;
    end
  end

  // Pin sequencer, one bus cycle at a time
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q + CNT_W'(1);
    cur_d   = cur_q;
    ctl_d   = ctl_q;
    oe_d    = oe_q;
    case (state_q)
      AMC_ST_BOOT: begin
        if (cnt_q >= CNT_W'(STARTUP_CNT - 1)) begin
          state_d = AMC_ST_IDLE;
        end
      end
      AMC_ST_IDLE: begin
        cnt_d = '0;
        if (req_valid && req_ready) begin
          cur_d      = req;
          ctl_d.addr = req.addr;
          ctl_d.chip_sel_n = 1'b0;
          ctl_d.upper_byte_sel_n = ~req.byte_en[1];
          ctl_d.lower_byte_sel_n = ~req.byte_en[0];
          if (req.write) begin
            ctl_d.write_n = 1'b0;
            oe_d          = 1'b1;
            state_d       = AMC_ST_WPUL;
          end else begin
            ctl_d.write_n   = 1'b1;
            ctl_d.out_drv_n = 1'b0;
            state_d         = AMC_ST_RACC;
          end
        end
      end
      AMC_ST_RACC: begin
        if (cnt_q >= CNT_W'(CYC_RACC + 1)) begin
          ctl_d.chip_sel_n = 1'b1;
          ctl_d.out_drv_n  = 1'b1;
          ctl_d.upper_byte_sel_n = 1'b1;
          ctl_d.lower_byte_sel_n = 1'b1;
          cnt_d   = '0;
          state_d = AMC_ST_RFLT;
        end
      end
      AMC_ST_RFLT: begin
        if (cnt_q >= CNT_W'(CYC_RFLT - 1)) begin
          cnt_d   = '0;
          state_d = AMC_ST_GAP;
        end
      end
      AMC_ST_WPUL: begin
        if (cnt_q >= CNT_W'(CYC_WP - 1)) begin
          ctl_d.write_n    = 1'b1;
          ctl_d.chip_sel_n = 1'b1;
          ctl_d.upper_byte_sel_n = 1'b1;
          ctl_d.lower_byte_sel_n = 1'b1;
          cnt_d   = '0;
          state_d = AMC_ST_WREC;
        end
      end
      AMC_ST_WREC: begin
        // Address and data held through recovery
        if (cnt_q >= CNT_W'(CYC_REC - 1)) begin
          oe_d    = 1'b0;
          cnt_d   = '0;
          state_d = AMC_ST_GAP;
        end
      end
      AMC_ST_GAP: begin
        // Controls stay high, cycle from address
        state_d = AMC_ST_IDLE;
      end
      default: state_d = AMC_ST_BOOT;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= AMC_ST_BOOT;
      cnt_q   <= '0;
      cur_q   <= '0;
      ctl_q   <= '{chip_sel_n: 1'b1, write_n: 1'b1, out_drv_n: 1'b1,
                   upper_byte_sel_n: 1'b1, lower_byte_sel_n: 1'b1, addr: '0};
      oe_q    <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      cur_q   <= cur_d;
      ctl_q   <= ctl_d;
      oe_q    <= oe_d;
    end
  end
endmodule : amc_host
`default_nettype wire

// [bench/amc_mem_model.sv]
// Behavioural model of the asynchronous 16-bit memory
`timescale 1ns/10ps
`default_nettype none
module amc_mem_model
  import amc_pkg::*;
#(parameter int ACC_NS = 35) (
  input  wire amc_pkg::amc_ctl_t          ctl,
  input  wire logic [amc_pkg::DATA_W-1:0] dq_bus,
  output logic [amc_pkg::DATA_W-1:0]      dq
);
  logic [DATA_W-1:0] mem_q [16];
  logic [DATA_W-1:0] rd_q;
  logic [DATA_W-1:0] last_q = '0;
  logic              drive;
  // Data settles an access time after address
  assign #(ACC_NS) rd_q = mem_q[ctl.addr[3:0]];
  // Drive only in a clean read
  assign drive = !ctl.chip_sel_n && !ctl.out_drv_n && ctl.write_n
                 && !(ctl.upper_byte_sel_n && ctl.lower_byte_sel_n);
  assign dq = drive ? rd_q : ~last_q;
  always @(dq) if (drive) last_q = dq;
  // Store during select and strobe overlap
  always @(ctl or dq_bus) begin
    if (!ctl.chip_sel_n && !ctl.write_n && !ctl.upper_byte_sel_n) mem_q[ctl.addr[3:0]][15:8] = dq_bus[15:8];
    if (!ctl.chip_sel_n && !ctl.write_n && !ctl.lower_byte_sel_n) mem_q[ctl.addr[3:0]][7:0] = dq_bus[7:0];
  end
endmodule : amc_mem_model
`default_nettype wire

// [bench/amc_host_props.sv]
// Pin timing checks for the memory host controller
`timescale 1ns/10ps
`default_nettype none
module amc_host_props
  import amc_pkg::*;
(
  input wire logic                       clk,
  input wire logic                       reset,
  input wire logic                       req_ready,
  input wire logic                       rd_valid,
  input wire amc_pkg::amc_ctl_t          mem_ctl,
  input wire logic [amc_pkg::DATA_W-1:0] mem_dq_out,
  input wire logic                       mem_dq_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_read_strobe_high: assert property (!mem_ctl.out_drv_n |-> mem_ctl.write_n && !mem_dq_oe)
    else $error("strobe low in read");
  a_select_spacing: assert property ($fell(mem_ctl.chip_sel_n) |=> !$fell(mem_ctl.chip_sel_n) [*4])
    else $error("select falls too close");
  a_select_rest: assert property ($rose(mem_ctl.chip_sel_n) |=> mem_ctl.chip_sel_n)
    else $error("select high too briefly");
  a_addr_held: assert property (!mem_ctl.chip_sel_n && !$fell(mem_ctl.chip_sel_n) |-> $stable(mem_ctl.addr))
    else $error("address moved in cycle");
  a_byte_skew: assert property (!mem_ctl.upper_byte_sel_n && !mem_ctl.lower_byte_sel_n
    |-> $fell(mem_ctl.upper_byte_sel_n) == $fell(mem_ctl.lower_byte_sel_n)) else $error("byte select skew");
  a_write_pulse: assert property ($fell(mem_ctl.write_n)
    |-> (!mem_ctl.write_n && !mem_ctl.chip_sel_n && mem_dq_oe) [*3]) else $error("write pulse short");
  a_write_hold: assert property ($rose(mem_ctl.write_n) |-> mem_dq_oe && $stable(mem_dq_out)
    && $stable(mem_ctl.addr) ##1 $stable(mem_ctl.addr)) else $error("write hold broken");
  a_read_answer: assert property ($fell(mem_ctl.out_drv_n) |-> ##[5:10] rd_valid)
    else $error("read answer late");
  a_boot_quiet: assert property ($fell(reset)
    |-> (mem_ctl.chip_sel_n && mem_ctl.write_n && !req_ready) [*8]) else $error("startup not quiet");
endmodule : amc_host_props
bind amc_host amc_host_props u_props (.clk(clk), .reset(reset), .req_ready(req_ready), .rd_valid(rd_valid),
  .mem_ctl(mem_ctl), .mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe));
`default_nettype wire

// [bench/tb.sv]
// Self-checking bench for the memory host controller
`timescale 1ns/10ps
`default_nettype none
module tb import amc_pkg::*;;
  logic              clk = 1'b0;
  logic              reset = 1'b1;
  amc_req_t          req = '0;
  logic              req_valid = 1'b0;
  logic              req_ready, rd_valid, oe;
  logic [DATA_W-1:0] rd_data, dq_out, dq_mem, dq_bus;
  amc_ctl_t          ctl;
  int                bad_count = 0;
  int                total_checks = 0;
  always #4 clk = ~clk;
  assign dq_bus = oe ? dq_out : dq_mem;
  amc_host #(.STARTUP_CNT(10)) DUT (.clk(clk), .reset(reset), .req(req), .req_valid(req_valid),
    .req_ready(req_ready), .rd_data(rd_data), .rd_valid(rd_valid), .mem_ctl(ctl),
    .mem_dq_in(dq_bus), .mem_dq_out(dq_out), .mem_dq_oe(oe));
  amc_mem_model MEM (.ctl(ctl), .dq_bus(dq_bus), .dq(dq_mem));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic op(input logic w, input logic [1:0] be, input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{w, be, ADDR_W'(a), d};
    req_valid <= 1'b1;
    do @(posedge clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
  endtask : op
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    op(1'b0, 2'b11, a, 16'h0000);
    repeat (20) begin
      @(posedge clk);
      if (rd_valid === 1'b1) break;
    end
    chk({15'h0000, rd_valid}, 16'h0001);
    chk(rd_data, exp);
  endtask : rd
  // Request held during startup must wait
  task automatic t_boot();
    fork
      op(1'b1, 2'b11, 4'h1, 16'h1234);
      repeat (8) @(posedge clk) chk({15'h0000, ctl.chip_sel_n & ctl.write_n & ~req_ready}, 16'h0001);
    join
    rd(4'h1, 16'h1234);
  endtask : t_boot
  // Single-byte and empty writes
  task automatic t_bytes();
    op(1'b1, 2'b10, 4'h1, 16'hABCD);
    rd(4'h1, 16'hAB34);
    op(1'b1, 2'b01, 4'h1, 16'h00EF);
    op(1'b1, 2'b00, 4'h1, 16'h5555);
    rd(4'h1, 16'hABEF);
  endtask : t_bytes
  // Write then reads at once, other address
  task automatic t_back2back();
    op(1'b1, 2'b11, 4'h2, 16'h0F0F);
    rd(4'h2, 16'h0F0F);
    rd(4'h1, 16'hABEF);
  endtask : t_back2back
  // Reset in mid-run: controls high, memory keeps its word
  task automatic t_reset();
    @(posedge clk);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk({15'h0000, ctl.chip_sel_n & ctl.write_n & ~req_ready}, 16'h0001);
    rd(4'h2, 16'h0F0F);
  endtask : t_reset
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  initial begin
    #20000;
    bad_count++;
    end_of_test();
  end
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    t_boot();
    t_bytes();
    t_back2back();
    t_reset();
    end_of_test();
  end
endmodule : tb
`default_nettype wire
